// ===== core/fasm_pkg.sv
// Constants and types for the flash address and sector map block
package fasm_pkg;
    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_BANK   = 8'h00;
    localparam logic [7:0] OFS_SR2    = 8'h04;
    localparam logic [7:0] OFS_FIRST_CONFIG_VOLATILE   = 8'h08;
    localparam logic [7:0] OFS_SECOND_CONFIG_VOLATILE   = 8'h0c;
    localparam logic [7:0] OFS_LAYOUT = 8'h10;
    localparam logic [7:0] OFS_LASTCMD = 8'h14;
    localparam logic [7:0] OFS_ADDR   = 8'h18;
    localparam logic [7:0] OFS_SECTOR = 8'h1c;
    localparam logic [7:0] OFS_FLAGS  = 8'h20;
    // Field positions
    localparam int BANK_EXT_BIT  = 7;
    localparam int SR2_ESZ_BIT   = 7;
    localparam int CR1_QUAD_BIT  = 1;
    localparam int CR2_IO3R_BIT  = 5;
    localparam int LAY_TOP_BIT   = 0;
    localparam int FLG_IGN_BIT   = 0;
    localparam int FLG_ID_BIT    = 1;
    localparam int SEC_SIZE_LSB  = 16;
    // Reset values
    localparam logic [7:0] BANK_RST = 8'h00;
    localparam logic [7:0] REG8_RST = 8'h00;
    // Command codes
    localparam logic [7:0] CMD_READ  = 8'h03;
    localparam logic [7:0] CMD_READ4 = 8'h13;
    localparam logic [7:0] CMD_SE    = 8'hd8;
    localparam logic [7:0] CMD_SE4   = 8'hdc;
    localparam logic [7:0] CMD_READ_IDENTIFICATION_CMD  = 8'h9f;
    localparam logic [7:0] CMD_PRMRD = 8'h4c;
    localparam logic [7:0] CMD_PRMWR = 8'h4d;
    // Frame lengths in bits
    localparam logic [5:0] CMD_BITS    = 6'h08;
    localparam logic [5:0] ADDR3_BITS  = 6'h18;
    localparam logic [5:0] ADDR4_BITS  = 6'h20;
    // Sector geometry
    localparam logic [7:0] HYB_LOW_BLK  = 8'h00;
    localparam logic [7:0] HYB_HIGH_BLK = 8'hff;
    localparam logic [8:0] BOT_BIG_IDX0 = 9'h00f;
    localparam logic [8:0] TOP_SML_IDX0 = 9'h0ff;
    localparam int SML_SHIFT = 12;
    localparam int BIG_SHIFT = 16;
    localparam int UNI_SHIFT = 18;

    typedef enum logic [1:0] {
        SZ_4K,
        SZ_64K,
        SZ_256K
    } fasm_size_type;

    typedef struct packed {
        logic [8:0]    index;
        fasm_size_type size;
        logic [23:0]   base;
    } fasm_sector_type;
endpackage

// ===== core/fasm_core.sv
// Serial flash address formation, sector map and identification space
// What this block does
// - With 24-bit legacy addresses the bank address register supplies the upper address bits.
// - With the extended mode bit set every legacy command takes a full 32-bit address.
// - Any reset clears the bank address register and selects 24-bit address mode.
// - The dual-purpose command variants always take a 32-bit address.
// - Address bits 31 to 24 are ignored; the array is decoded with the low 24 bits.
// - Commands for the separate spaces still take a full 32-bit address.
// - The erase-size bit of the second status register picks hybrid or uniform sectors.
// - Hybrid bottom maps sixteen 4-kB sectors under 64-kB sectors from 00010000h.
// - Hybrid top maps 64-kB sectors from zero and sixteen 4-kB sectors from 00ff0000h.
// - Uniform layout gives 64 sectors of 256 kB starting at zero.
// - Sectors are aligned to their size; upper bits select, lower bits index.
// - Instruction 9fh reads the identification space instead of the array.
// - The identification space is read only; host program or erase is ignored.
// - The Shared_pin_a acts only when both volatile config enable bits are set.
//
// Chosen here: register access over APB and the placing of the registers.
module fasm_core
    import fasm_pkg::*;
#(
    parameter logic [31:0] ID_WORD = 32'h5a3c_0f01  // Arbitrary identification content
) (
    input  wire logic        pclk,           // Bus clock, 25 MHz
    input  wire logic        presetn,        // Asynchronous reset, active low
    input  wire logic        psel,           // APB select
    input  wire logic        penable,        // APB access phase
    input  wire logic        pwrite,         // APB write
    input  wire logic [7:0]  paddr,          // APB byte address
    input  wire logic [31:0] pwdata,         // APB write data
    output logic      [31:0] prdata,         // APB read data
    output logic             pready,         // APB ready
    output logic             pslverr,        // APB error on unmapped address
    input  wire logic        sck,            // Serial clock pin
    input  wire logic        cs_n,           // Chip select pin, active low
    input  wire logic        si,             // Serial data in pin
    output logic             so_out,         // Serial data out value
    output logic             so_oe_n,        // Serial data out enable, active low
    input  wire logic        shared_pin_a,   // Shared Shared_pin_a pin level
    output logic             erase_pulse,    // One-cycle erase request
    output fasm_sector_type  erase_sector,   // Sector of the erase request
    output logic             pin_reset       // One-cycle reset from shared pin
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CMD,
        ST_ADDR,
        ST_DATA
    } fasm_state_type;

    logic [2:0] sck_sync, cs_sync, io3_sync;
    logic [1:0] si_sync;
    logic       sck_rise, sck_fall, cs_active, cs_rise;
    fasm_state_type state_reg;
    logic [5:0]  bit_cnt_reg;
    logic [31:0] rx_reg;
    logic [7:0]  cmd_reg;
    logic [31:0] full_addr_reg;
    logic [23:0] eff_addr_reg;
    logic [7:0]  bank_reg, sr2_reg, first_config_volatile_reg, second_config_volatile_reg, layout_reg;
    logic        ign_reg, id_reg;
    logic [31:0] out_sh_reg;
    logic        load_pend_reg, out_en_reg;
    logic        addr_done, use_4b, addr_cmd, is_prm;
    logic [5:0]  addr_bits;
    logic [31:0] addr_next;
    fasm_sector_type sec_next, sector_reg;
    logic        wr_en, rd_en, mapped;
    logic        soft_rst;
    logic [31:0] rd_mux;

    // Pin synchronisers, stage 0 read only by stage 1
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_sync <= 3'h0;
            cs_sync  <= 3'h7;
            si_sync  <= 2'h0;
            io3_sync <= 3'h7;
        end else begin
            sck_sync <= {sck_sync[1:0], sck};
            cs_sync  <= {cs_sync[1:0], cs_n};
            si_sync  <= {si_sync[0], si};
            io3_sync <= {io3_sync[1:0], shared_pin_a};
        end
    end

    assign sck_rise  = sck_sync[1] & ~sck_sync[2];
    assign sck_fall  = ~sck_sync[1] & sck_sync[2];
    assign cs_active = ~cs_sync[1];
    assign cs_rise   = cs_sync[1] & ~cs_sync[2];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_reset <= 1'b0;
        end else begin
            pin_reset <= second_config_volatile_reg[CR2_IO3R_BIT] & first_config_volatile_reg[CR1_QUAD_BIT]
                       & cs_sync[1] & ~io3_sync[1] & io3_sync[2];
        end
    end
    assign soft_rst = pin_reset;

    // dual-purpose commands always use four bytes
    // separate-space commands use four bytes too
    // extended mode makes legacy commands four bytes
    always_comb begin
        is_prm   = (cmd_reg == CMD_PRMRD) || (cmd_reg == CMD_PRMWR);
        addr_cmd = (cmd_reg == CMD_READ) || (cmd_reg == CMD_SE);
        use_4b   = (cmd_reg == CMD_READ4) || (cmd_reg == CMD_SE4) || is_prm
                 || (addr_cmd && bank_reg[BANK_EXT_BIT]);
        addr_bits = use_4b ? ADDR4_BITS : ADDR3_BITS;
        addr_done = (state_reg == ST_ADDR) && sck_rise && (bit_cnt_reg == addr_bits - 6'h01);
    end

    always_comb begin
        if (use_4b) begin
            addr_next = {rx_reg[30:0], si_sync[1]};
        end else begin
            addr_next = {1'b0, bank_reg[6:0], rx_reg[22:0], si_sync[1]};
        end
    end

    // sector from effective address and layout
    // erase-size bit selects uniform or hybrid
    always_comb begin
        sec_next = '0;
        if (sr2_reg[SR2_ESZ_BIT]) begin
            sec_next.size  = SZ_256K;
            sec_next.index = {3'h0, eff_addr_reg[23:UNI_SHIFT]};
            sec_next.base  = {eff_addr_reg[23:UNI_SHIFT], 18'h00000};
        end else if (layout_reg[LAY_TOP_BIT]) begin
            // small sectors in the top 64 kB
            if (eff_addr_reg[23:BIG_SHIFT] == HYB_HIGH_BLK) begin
                sec_next.size  = SZ_4K;
                sec_next.index = TOP_SML_IDX0 + {5'h00, eff_addr_reg[15:SML_SHIFT]};
                sec_next.base  = {eff_addr_reg[23:SML_SHIFT], 12'h000};
            end else begin
                sec_next.size  = SZ_64K;
                sec_next.index = {1'b0, eff_addr_reg[23:BIG_SHIFT]};
                sec_next.base  = {eff_addr_reg[23:BIG_SHIFT], 16'h0000};
            end
        end else begin
            // small sectors in the bottom 64 kB
            if (eff_addr_reg[23:BIG_SHIFT] == HYB_LOW_BLK) begin
                sec_next.size  = SZ_4K;
                sec_next.index = {5'h00, eff_addr_reg[15:SML_SHIFT]};
                sec_next.base  = {eff_addr_reg[23:SML_SHIFT], 12'h000};
            end else begin
                sec_next.size  = SZ_64K;
                sec_next.index = BOT_BIG_IDX0 + {1'b0, eff_addr_reg[23:BIG_SHIFT]};
                sec_next.base  = {eff_addr_reg[23:BIG_SHIFT], 16'h0000};
            end
        end
    end

    // Serial frame sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg   <= ST_IDLE;
            bit_cnt_reg <= 6'h00;
            rx_reg      <= 32'h0;
            cmd_reg     <= 8'h00;
        end else if (!cs_active || soft_rst) begin
            state_reg   <= ST_IDLE;
            bit_cnt_reg <= 6'h00;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    state_reg   <= ST_CMD;
                    bit_cnt_reg <= 6'h00;
                end
                ST_CMD: begin
                    if (sck_rise) begin
                        rx_reg      <= {rx_reg[30:0], si_sync[1]};
                        bit_cnt_reg <= bit_cnt_reg + 6'h01;
                        if (bit_cnt_reg == CMD_BITS - 6'h01) begin
                            cmd_reg     <= {rx_reg[6:0], si_sync[1]};
                            bit_cnt_reg <= 6'h00;
                            state_reg   <= ({rx_reg[6:0], si_sync[1]} == CMD_READ_IDENTIFICATION_CMD)
                                           ? ST_DATA : ST_ADDR;
                        end
                    end
                end
                ST_ADDR: begin
                    if (sck_rise) begin
                        rx_reg      <= addr_next;
                        bit_cnt_reg <= bit_cnt_reg + 6'h01;
                        if (addr_done) begin
                            state_reg <= ST_DATA;
                        end
                    end
                end
                ST_DATA: begin
                    state_reg <= ST_DATA;
                end
            endcase
        end
    end

    // Captured address of the frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            full_addr_reg <= 32'h0;
            eff_addr_reg  <= 24'h0;
        end else if (addr_done) begin
            full_addr_reg <= addr_next;
            // upper byte dropped for the array
            eff_addr_reg  <= addr_next[23:0];
        end
    end

    // Read data out of the identification space
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_sh_reg    <= 32'h0;
            load_pend_reg <= 1'b0;
            out_en_reg    <= 1'b0;
        end else if (!cs_active) begin
            load_pend_reg <= 1'b0;
            out_en_reg    <= 1'b0;
        end else if (sck_rise && (state_reg == ST_CMD) && (bit_cnt_reg == CMD_BITS - 6'h01)
                     && ({rx_reg[6:0], si_sync[1]} == CMD_READ_IDENTIFICATION_CMD)) begin
            load_pend_reg <= 1'b1;
            out_sh_reg    <= ID_WORD;
        end else if (addr_done && (cmd_reg == CMD_PRMRD)) begin
            load_pend_reg <= 1'b1;
            out_sh_reg    <= ID_WORD << {addr_next[1:0], 3'h0};
        end else if (sck_fall && load_pend_reg) begin
            load_pend_reg <= 1'b0;
            out_en_reg    <= 1'b1;
        end else if (sck_fall && out_en_reg) begin
            out_sh_reg <= {out_sh_reg[30:0], out_sh_reg[31]};
        end
    end

    always_comb begin
        so_out  = out_sh_reg[31];
        so_oe_n = ~out_en_reg;
    end

    // Erase request and sector status at end of frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            erase_pulse  <= 1'b0;
            erase_sector <= '0;
            sector_reg   <= '0;
        end else begin
            erase_pulse <= 1'b0;
            if (cs_rise && (state_reg == ST_DATA)) begin
                sector_reg <= sec_next;
                if ((cmd_reg == CMD_SE) || (cmd_reg == CMD_SE4)) begin
                    erase_pulse  <= 1'b1;
                    erase_sector <= sec_next;
                end
            end
        end
    end

    // APB decode
    always_comb begin
        wr_en  = psel & penable & pwrite;
        rd_en  = psel & ~penable & ~pwrite;
        pready = 1'b1;
        unique case (paddr)
            OFS_BANK, OFS_SR2, OFS_FIRST_CONFIG_VOLATILE, OFS_SECOND_CONFIG_VOLATILE, OFS_LAYOUT,
            OFS_LASTCMD, OFS_ADDR, OFS_SECTOR, OFS_FLAGS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
        pslverr = psel & penable & ~mapped;
    end

    // bank register cleared by any reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bank_reg <= BANK_RST;
        end else if (soft_rst) begin
            bank_reg <= BANK_RST;
        end else if (wr_en && (paddr == OFS_BANK)) begin
            bank_reg <= pwdata[7:0];
        end
    end

    // Configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sr2_reg    <= REG8_RST;
            first_config_volatile_reg   <= REG8_RST;
            second_config_volatile_reg   <= REG8_RST;
            layout_reg <= REG8_RST;
        end else if (wr_en) begin
            if (paddr == OFS_SR2) begin
                sr2_reg <= pwdata[7:0];
            end
            if (paddr == OFS_FIRST_CONFIG_VOLATILE) begin
                first_config_volatile_reg <= pwdata[7:0];
            end
            if (paddr == OFS_SECOND_CONFIG_VOLATILE) begin
                second_config_volatile_reg <= pwdata[7:0];
            end
            if (paddr == OFS_LAYOUT) begin
                layout_reg <= pwdata[7:0];
            end
        end
    end

    // host writes to identification space ignored and flagged
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ign_reg <= 1'b0;
            id_reg  <= 1'b0;
        end else begin
            if (addr_done && (cmd_reg == CMD_PRMWR)) begin
                ign_reg <= 1'b1;
            end else if (wr_en && (paddr == OFS_FLAGS) && pwdata[FLG_IGN_BIT]) begin
                ign_reg <= 1'b0;
            end
            if (cs_rise) begin
                id_reg <= (cmd_reg == CMD_READ_IDENTIFICATION_CMD) || is_prm;
            end
        end
    end

    always_comb begin
        rd_mux = 32'h0;
        unique case (paddr)
            OFS_BANK:    rd_mux[7:0] = bank_reg;
            OFS_SR2:     rd_mux[7:0] = sr2_reg;
            OFS_FIRST_CONFIG_VOLATILE:    rd_mux[7:0] = first_config_volatile_reg;
            OFS_SECOND_CONFIG_VOLATILE:    rd_mux[7:0] = second_config_volatile_reg;
            OFS_LAYOUT:  rd_mux[7:0] = layout_reg;
            OFS_LASTCMD: rd_mux[7:0] = cmd_reg;
            OFS_ADDR:    rd_mux      = full_addr_reg;
            OFS_SECTOR: begin
                rd_mux[8:0] = sector_reg.index;
                rd_mux[SEC_SIZE_LSB +: 2] = sector_reg.size;
            end
            OFS_FLAGS: begin
                rd_mux[FLG_IGN_BIT] = ign_reg;
                rd_mux[FLG_ID_BIT]  = id_reg;
            end
            default:     rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (rd_en) begin
            prdata <= rd_mux;
        end
    end
endmodule

// ===== dv/fasm_chk.sv
// Assertion checker for the flash address and sector map block
module fasm_chk
    import fasm_pkg::*;
(
    input wire logic            pclk,         // Bus clock
    input wire logic            presetn,      // Reset, active low
    input wire logic            psel,         // APB select
    input wire logic            penable,      // APB access phase
    input wire logic            pwrite,       // APB write
    input wire logic [7:0]      paddr,        // APB address
    input wire logic [31:0]     pwdata,       // APB write data
    input wire logic [31:0]     prdata,       // APB read data
    input wire logic            pready,       // APB ready
    input wire logic            pslverr,      // APB error
    input wire logic            sck,          // Serial clock
    input wire logic            cs_n,         // Chip select, active low
    input wire logic            si,           // Serial data in
    input wire logic            so_out,       // Serial data out
    input wire logic            so_oe_n,      // Output enable, active low
    input wire logic            shared_pin_a, // Shared IO3 pin
    input wire logic            erase_pulse,  // Erase request
    input wire fasm_sector_type erase_sector, // Erase target
    input wire logic            pin_reset     // Reset from shared pin
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic       uni_reg, top_reg, quad_reg, io3r_reg, mapped;
    logic [7:0] cs_cnt_reg, blk;
    logic [8:0] idx_exp;
    fasm_size_type size_exp;
    assign mapped = (paddr <= OFS_FLAGS) && (paddr[1:0] == 2'h0);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {uni_reg, top_reg, quad_reg, io3r_reg} <= 4'h0;
        end else if (psel && penable && pwrite && pready) begin
            if (paddr == OFS_SR2) uni_reg <= pwdata[SR2_ESZ_BIT];
            if (paddr == OFS_LAYOUT) top_reg <= pwdata[LAY_TOP_BIT];
            if (paddr == OFS_FIRST_CONFIG_VOLATILE) quad_reg <= pwdata[CR1_QUAD_BIT];
            if (paddr == OFS_SECOND_CONFIG_VOLATILE) io3r_reg <= pwdata[CR2_IO3R_BIT];
        end
    end
    // Cycles since chip select went high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) cs_cnt_reg <= 8'hff;
        else if (!cs_n) cs_cnt_reg <= 8'h00;
        else if (cs_cnt_reg != 8'hff) cs_cnt_reg <= cs_cnt_reg + 8'h01;
    end
    always_comb begin
        blk = erase_sector.base[23:16];
        size_exp = SZ_64K;
        if (uni_reg) begin
            idx_exp = {3'h0, erase_sector.base[23:18]};
            size_exp = SZ_256K;
        end else if (top_reg && blk == HYB_HIGH_BLK) begin
            idx_exp = TOP_SML_IDX0 + {5'h00, erase_sector.base[15:12]};
            size_exp = SZ_4K;
        end else if (top_reg) begin
            idx_exp = {1'b0, blk};
        end else if (blk == HYB_LOW_BLK) begin
            idx_exp = {5'h00, erase_sector.base[15:12]};
            size_exp = SZ_4K;
        end else begin
            idx_exp = BOT_BIG_IDX0 + {1'b0, blk};
        end
    end
    chk_ready_high: assert property (pready) else $error("pready low");
    chk_unmapped_err: assert property (psel && penable && !mapped |-> pslverr)
        else $error("no error on unmapped access");
    chk_mapped_ok: assert property (psel && penable && mapped |-> !pslverr)
        else $error("error on mapped access");
    chk_unmapped_zero: assert property (psel && penable && !pwrite && !mapped
        |-> prdata == 32'h0) else $error("unmapped read not zero");
    chk_erase_single: assert property (erase_pulse |=> !erase_pulse)
        else $error("erase pulse too long");
    chk_erase_after_cs: assert property (erase_pulse |-> cs_n && cs_cnt_reg inside {[1:8]})
        else $error("erase not after frame end");
    chk_sector_size: assert property (erase_pulse |-> erase_sector.size == size_exp)
        else $error("wrong sector size");
    chk_sector_index: assert property (erase_pulse
        |-> erase_sector.index == idx_exp) else $error("wrong sector index");
    chk_sector_align: assert property (erase_pulse |-> erase_sector.base[11:0] == 12'h000
        && (size_exp == SZ_4K || erase_sector.base[15:12] == 4'h0)
        && (size_exp != SZ_256K || erase_sector.base[17:16] == 2'h0))
        else $error("base unaligned");
    chk_oe_idle: assert property (cs_n [*5] |-> so_oe_n)
        else $error("driving while deselected");
    chk_pin_reset_en: assert property (pin_reset |-> quad_reg && io3r_reg && cs_n)
        else $error("pin reset while disabled");
    chk_pin_reset_one: assert property ($rose(pin_reset) |=> $fell(pin_reset))
        else $error("pin reset too long");
    cov_uniform: cover property (erase_pulse && erase_sector.size == SZ_256K);
    cov_small: cover property (erase_pulse && erase_sector.size == SZ_4K);
    cov_pin_reset: cover property (pin_reset);
    cov_unmapped: cover property (psel && penable && pslverr);
endmodule

bind fasm_core fasm_chk i_fasm_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sck, .cs_n, .si, .so_out, .so_oe_n, .shared_pin_a,
    .erase_pulse, .erase_sector, .pin_reset);

// ===== dv/fasm_host.sv
// Host serial controller model driving the flash pins
module fasm_host (
    output logic     sck,  // Serial clock, still outside frames
    output logic     cs_n, // Chip select, active low
    output logic     si,   // Serial data to the device
    output logic     io3,  // Shared Shared_pin_a level
    input wire logic so    // Serial data from the device
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] rx;
    initial begin
        {sck, si, rx} = '0;
        {cs_n, io3} = 2'h3;
    end
    task automatic frame(input logic [7:0] cmd, input logic [31:0] a, input int na, input int nd);
        logic [63:0] sh;
        sh = {cmd, a << (32 - na), 24'h000000};
        #13 cs_n = 1'b0;
        for (int i = 0; i < 8 + na + nd; i++) begin
            si = sh[63];
            sh = sh << 1;
            #160 sck = 1'b1;
            if (i >= 8 + na) rx = {rx[30:0], so};
            #160 sck = 1'b0;
        end
        #160 cs_n = 1'b1;
        si = ~si;
        #320;
    endtask
    task automatic reset_pulse;
        #13 io3 = 1'b0;
        #400 io3 = 1'b1;
        #400;
    endtask
endmodule

// ===== dv/fasm_core_test.sv
// Testbench for the flash address and sector map block
module fasm_core_test;
    import fasm_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] ID_W = 32'h6b2d_90e4; // Arbitrary identification content
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic sck, cs_n, si, so_out, so_oe_n, shared_pin_a, erase_pulse, pin_reset;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    fasm_sector_type erase_sector, esec;
    int error_cnt = 0, n_tests = 0, ecnt = 0, prc = 0, cyc = 0;
    fasm_core #(.ID_WORD(ID_W)) i_fasm_core (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .sck, .cs_n, .si, .so_out, .so_oe_n, .shared_pin_a,
        .erase_pulse, .erase_sector, .pin_reset);
    fasm_host i_fasm_host (.sck, .cs_n, .si, .io3(shared_pin_a), .so(so_out ^ so_oe_n));
    always #20 pclk = ~pclk;
    always @(posedge pclk) begin
        if (erase_pulse === 1'b1) ecnt <= ecnt + 1;
        if (erase_pulse === 1'b1) esec <= erase_sector;
        if (pin_reset === 1'b1) prc <= prc + 1;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            conclude();
        end
    end
    task automatic conclude;
        $display("errors %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [63:0] g, input logic [63:0] x);
        n_tests++;
        if (g !== x) begin
            error_cnt++;
            $display("BAD %0t got %h expected %h", $time, g, x);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk({e, q}, {1'b0, x});
    endtask
    task automatic se(input logic [7:0] s2, ly, bk, cmd, input int na, input logic [31:0] a, fa,
                      input fasm_sector_type x);
        int n;
        wr(OFS_SR2, {24'h0, s2});
        wr(OFS_LAYOUT, {24'h0, ly});
        wr(OFS_BANK, {24'h0, bk});
        n = ecnt;
        i_fasm_host.frame(cmd, a, na, 0);
        repeat (2) @(posedge pclk);
        chk(ecnt, n + 1);
        chk(esec, x);
        rd(OFS_ADDR, fa);
    endtask
    initial begin
        logic [31:0] q;
        logic e;
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a <= 32; a += 4) rd(8'(a), 32'h0);
        se(8'h00, 8'h00, 8'h00, CMD_SE, 24, 32'h0, 32'h0, {9'h000, SZ_4K, 24'h0});
        se(8'h00, 8'h00, 8'h00, CMD_SE, 24, 32'hf123, 32'hf123, {9'h00f, SZ_4K, 24'hf000});
        se(8'h00, 8'h00, 8'h05, CMD_SE, 24, 32'h10000, 32'h05010000,
           {9'h010, SZ_64K, 24'h010000});
        se(8'h00, 8'h01, 8'h00, CMD_SE4, 32, 32'habff0fff, 32'habff0fff,
           {9'h0ff, SZ_4K, 24'hff0000});
        se(8'h00, 8'h01, 8'h00, CMD_SE, 24, 32'hfff000, 32'hfff000,
           {9'h10e, SZ_4K, 24'hfff000});
        se(8'h00, 8'h01, 8'h80, CMD_SE, 32, 32'h12feabcd, 32'h12feabcd,
           {9'h0fe, SZ_64K, 24'hfe0000});
        se(8'h80, 8'h01, 8'h00, CMD_SE, 24, 32'hfc1234, 32'hfc1234,
           {9'h03f, SZ_256K, 24'hfc0000});
        se(8'h80, 8'h00, 8'h03, CMD_SE, 24, 32'h40000, 32'h03040000,
           {9'h001, SZ_256K, 24'h040000});
        i_fasm_host.frame(CMD_READ, 32'h123456, 24, 8);
        rd(OFS_ADDR, 32'h03123456);
        i_fasm_host.frame(CMD_READ4, 32'h89abcdef, 32, 8);
        rd(OFS_ADDR, 32'h89abcdef);
        rd(OFS_LASTCMD, {24'h0, CMD_READ4});
        i_fasm_host.frame(CMD_PRMRD, 32'h77000000, 32, 32);
        chk(i_fasm_host.rx, ID_W);
        rd(OFS_ADDR, 32'h77000000);
        i_fasm_host.frame(CMD_READ_IDENTIFICATION_CMD, 32'h0, 0, 32);
        rd(OFS_LASTCMD, {24'h0, CMD_READ_IDENTIFICATION_CMD});
        apb(1'b0, OFS_FLAGS, 32'h0, q, e);
        chk(q[FLG_ID_BIT], 1'b1);
        i_fasm_host.frame(CMD_PRMWR, 32'h10, 32, 8);
        chk(ecnt, 8);
        apb(1'b0, OFS_FLAGS, 32'h0, q, e);
        chk(q[FLG_IGN_BIT], 1'b1);
        wr(OFS_FLAGS, 32'h1);
        apb(1'b0, OFS_FLAGS, 32'h0, q, e);
        chk(q[FLG_IGN_BIT], 1'b0);
        apb(1'b1, 8'h24, 32'h5, q, e);
        chk(e, 1'b1);
        apb(1'b0, 8'h24, 32'h0, q, e);
        chk({e, q}, {1'b1, 32'h0});
        wr(OFS_BANK, 32'h05);
        wr(OFS_FIRST_CONFIG_VOLATILE, 32'h02);
        i_fasm_host.reset_pulse();
        chk(prc, 0);
        rd(OFS_BANK, 32'h05);
        wr(OFS_SECOND_CONFIG_VOLATILE, 32'h20);
        i_fasm_host.reset_pulse();
        chk(prc, 1);
        rd(OFS_BANK, 32'h0);
        conclude();
    end
endmodule
